// File: shared/ext_irq_pkg.sv
// Shared constants and types for the external interrupt input block.
package ext_irq_pkg;

  // Geometry.
  localparam int unsigned LINE_COUNT   = 4;
  localparam int unsigned REG_WIDTH    = 8;
  localparam int unsigned STATUS_WIDTH = 5;

  // Register byte addresses on the peripheral bus.
  localparam logic [31:0] FLAG_ADDR     = 32'hE01F_C140;
  localparam logic [31:0] WAKE_EN_ADDR  = 32'hE01F_C144;
  localparam logic [31:0] SENSE_ADDR    = 32'hE01F_C148;
  localparam logic [31:0] POLARITY_ADDR = 32'hE01F_C14C;
  localparam logic [31:0] STATUS_ADDR   = 32'hE01F_C150;
  localparam logic [31:0] MASK_ADDR     = 32'hE01F_C154;

  // Values after reset.
  localparam logic [3:0] FLAG_RESET     = 4'h0;
  localparam logic [3:0] WAKE_EN_RESET  = 4'h0;
  localparam logic [3:0] SENSE_RESET    = 4'h0;
  localparam logic [3:0] POLARITY_RESET = 4'h0;
  localparam logic [4:0] STATUS_RESET   = 5'h00;
  localparam logic [4:0] MASK_RESET     = 5'h00;
  // The pins idle high, so the edge detector starts at the idle level and sees no false edge.
  localparam logic       PIN_PREV_RESET = 1'h1;

  // Field encodings and positions.
  localparam logic        SENSE_LEVEL     = 1'h0;
  localparam logic        SENSE_EDGE      = 1'h1;
  localparam logic        POL_LOW_FALL    = 1'h0;
  localparam logic        POL_HIGH_RISE   = 1'h1;
  localparam int unsigned STATUS_WAKE_BIT = 4;

  // Bus handshake phase of the register slave.
  typedef enum logic {
    PH_IDLE = 1'b0,
    PH_ACK  = 1'b1
  } apb_phase_t;

endpackage

// File: core/ext_irq_line_cell.sv
// One external interrupt line: pin qualification, sense detection and pending flag.
`timescale 1ns/100ps
`default_nettype none

module ext_irq_line_cell (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // Pin side
  input  wire logic pin,
  input  wire logic func_sel,
  // Configuration
  input  wire logic edge_mode,
  input  wire logic active_high,
  // Software clear request, one cycle
  input  wire logic clear_req,
  // Results
  output var  logic flag,
  output var  logic set_now
);

  logic prev_pin;
  logic active;
  logic prev_active;

  always_ff @(posedge clock) begin
    if (rst) begin
      prev_pin <= ext_irq_pkg::PIN_PREV_RESET;
    end else begin
      prev_pin <= pin;
    end
  end

  // Gating by the function select on both samples avoids a false edge when the pin is mapped.
  always_comb begin
    active      = func_sel & ((active_high == ext_irq_pkg::POL_HIGH_RISE) ? pin : ~pin); // see R11
    prev_active = func_sel & ((active_high == ext_irq_pkg::POL_HIGH_RISE) ? prev_pin : ~prev_pin);
    if (edge_mode == ext_irq_pkg::SENSE_EDGE) begin // see R9
      set_now = active & ~prev_active;
    end else begin
      set_now = active;
    end
  end

  // In level mode an active pin keeps setting the flag, so a clear cannot take hold then.
  always_ff @(posedge clock) begin
    if (rst) begin
      flag <= 1'h0;
    end else begin
      flag <= set_now | (flag & ~clear_req); // see R8
    end
  end

endmodule

`default_nettype wire

// File: core/ext_irq_inputs.sv
// External interrupt inputs with flag, wake, sense and polarity registers on APB.
//
// Overview of operation
// [R1] Four independent lines exist, each live only while its pin function is selected.
// [R2] Any line may be configured to bring the processor out of Power Down.
// [R3] The flag register at the first address holds one pending flag per line, read-write.
// [R4] The wake-enable register holds one bit per line letting that line wake from Power Down.
// [R5] The sense register chooses level or edge detection separately per line.
// [R6] The polarity register chooses the active level or edge direction per line.
// [R7] Level mode sets the flag while the pin is active; edge mode sets it on the chosen edge.
// [R8] Writing one clears a flag, except in level mode while the pin is still active.
// [R9] A sense bit of zero means level sensitivity and one means edge sensitivity.
// [R10] Wakeup happens for an enabled line regardless of its enable in the vectored controller.
// [R11] Polarity zero means active-low or falling edge, one means active-high or rising edge.
//
// Our own choice: the APB register port.
`timescale 1ns/100ps
`default_nettype none

module ext_irq_inputs (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // External interrupt pins
  input  wire logic        ext_irq_line_a,
  input  wire logic        ext_irq_line_b,
  input  wire logic        ext_irq_line_c,
  input  wire logic        ext_irq_line_d,
  // Pin function selects, one per line
  input  wire logic [3:0]  pin_func_sel,
  // Power state from the power controller
  input  wire logic        power_down,
  // To the vectored interrupt controller and power controller
  output var  logic [3:0]  irq_flag_out,
  output var  logic        wake_request,
  // Summary interrupt
  output var  logic        irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations

  // Register bus phase and decoded strobes.
  ext_irq_pkg::apb_phase_t phase;
  ext_irq_pkg::apb_phase_t next_phase;
  logic                    access_cycle;
  logic                    commit_cycle;
  logic                    bus_write;
  logic                    addr_known;
  logic [31:0]             next_rdata;

  // Configuration registers, one bit per line.
  logic [3:0]              wake_enable_reg;
  logic [3:0]              sense_select_reg;
  logic [3:0]              polarity_select_reg;

  // Interrupt status and mask: the lines in bits 3:0 and the wake event above them.
  logic [4:0]              status_reg;
  logic [4:0]              mask_reg;
  logic [4:0]              status_events;
  logic [4:0]              status_clear;
  logic [4:0]              next_status;
  logic [4:0]              next_mask;

  // Per-line signals.
  logic [3:0]              pin_vec;
  logic [3:0]              irq_flag_reg;
  logic [3:0]              set_vec;
  logic [3:0]              clear_vec;
  logic [3:0]              clear_eff;
  logic                    next_wake;

  ////////////////////////////////////////////////////////////////////////////////
  // Address decoding

  // Exact word match: unaligned or foreign addresses hit nothing and answer with an error.
  function automatic logic addr_hit(
    input logic [31:0] addr,
    input logic [31:0] target
  );
    addr_hit = (addr == target);
  endfunction

  always_comb begin
    addr_known = addr_hit(paddr, ext_irq_pkg::FLAG_ADDR)
               | addr_hit(paddr, ext_irq_pkg::WAKE_EN_ADDR)
               | addr_hit(paddr, ext_irq_pkg::SENSE_ADDR)
               | addr_hit(paddr, ext_irq_pkg::POLARITY_ADDR)
               | addr_hit(paddr, ext_irq_pkg::STATUS_ADDR)
               | addr_hit(paddr, ext_irq_pkg::MASK_ADDR);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bus handshake

  // Every transfer gets exactly one wait state: the answer stands in the cycle after the
  // first access cycle, which lets read data come straight out of a register.
  always_comb begin
    next_phase = phase;
    unique case (phase)
      ext_irq_pkg::PH_IDLE: begin
        if (psel && penable) begin
          next_phase = ext_irq_pkg::PH_ACK;
        end
      end
      ext_irq_pkg::PH_ACK: begin
        next_phase = ext_irq_pkg::PH_IDLE;
      end
    endcase
  end

  always_comb begin
    access_cycle = psel & penable & (phase == ext_irq_pkg::PH_IDLE);
    commit_cycle = psel & penable & (phase == ext_irq_pkg::PH_ACK);
    bus_write    = commit_cycle & pwrite & addr_known;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      phase <= ext_irq_pkg::PH_IDLE;
    end else begin
      phase <= next_phase;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pready <= 1'b0;
    end else begin
      pready <= (next_phase == ext_irq_pkg::PH_ACK);
    end
  end

  // The error flag is produced with the answer and means something only while pready is high.
  always_ff @(posedge clock) begin
    if (rst) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= access_cycle & ~addr_known;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (addr_hit(paddr, ext_irq_pkg::FLAG_ADDR)) begin
      next_rdata = {28'h000_0000, irq_flag_reg}; // see R3
    end
    if (addr_hit(paddr, ext_irq_pkg::WAKE_EN_ADDR)) begin
      next_rdata = {28'h000_0000, wake_enable_reg}; // see R4
    end
    if (addr_hit(paddr, ext_irq_pkg::SENSE_ADDR)) begin
      next_rdata = {28'h000_0000, sense_select_reg}; // see R5
    end
    if (addr_hit(paddr, ext_irq_pkg::POLARITY_ADDR)) begin
      next_rdata = {28'h000_0000, polarity_select_reg}; // see R6
    end
    if (addr_hit(paddr, ext_irq_pkg::STATUS_ADDR)) begin
      next_rdata = {27'h000_0000, status_reg};
    end
    if (addr_hit(paddr, ext_irq_pkg::MASK_ADDR)) begin
      next_rdata = {27'h000_0000, mask_reg};
    end
  end

  // Taken in the first access cycle, so a read shows the state one cycle before the answer.
  always_ff @(posedge clock) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (access_cycle && !pwrite) begin
      prdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  always_ff @(posedge clock) begin
    if (rst) begin
      wake_enable_reg <= ext_irq_pkg::WAKE_EN_RESET;
    end else if (bus_write && addr_hit(paddr, ext_irq_pkg::WAKE_EN_ADDR)) begin
      wake_enable_reg <= pwdata[3:0]; // see R4
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      sense_select_reg <= ext_irq_pkg::SENSE_RESET;
    end else if (bus_write && addr_hit(paddr, ext_irq_pkg::SENSE_ADDR)) begin
      sense_select_reg <= pwdata[3:0]; // see R5
    end
  end

  // A sense or polarity change can itself look like an event, so software clears the flag after.
  always_ff @(posedge clock) begin
    if (rst) begin
      polarity_select_reg <= ext_irq_pkg::POLARITY_RESET;
    end else if (bus_write && addr_hit(paddr, ext_irq_pkg::POLARITY_ADDR)) begin
      polarity_select_reg <= pwdata[3:0]; // see R6
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt lines

  // The clear strobe lives for the committing cycle only; a set in that cycle wins.
  always_comb begin
    clear_vec = 4'h0;
    if (bus_write && addr_hit(paddr, ext_irq_pkg::FLAG_ADDR)) begin
      clear_vec = pwdata[3:0]; // see R8
    end
    clear_eff = clear_vec & ~set_vec;
  end

  assign pin_vec = {ext_irq_line_d, ext_irq_line_c, ext_irq_line_b, ext_irq_line_a};

  generate
    for (genvar i = 0; i < ext_irq_pkg::LINE_COUNT; i++) begin : g_line
      ext_irq_line_cell u_cell (
        .clock       (clock),
        .rst         (rst),
        .pin         (pin_vec[i]),
        .func_sel    (pin_func_sel[i]), // see R1
        .edge_mode   (sense_select_reg[i]),
        .active_high (polarity_select_reg[i]),
        .clear_req   (clear_vec[i]),
        .flag        (irq_flag_reg[i]), // see R7
        .set_now     (set_vec[i])
      );
    end
  endgenerate

  // The flags are flip-flops inside the line cells and go out unchanged.
  assign irq_flag_out = irq_flag_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Wakeup

  // The local mask plays no part here, so a line can wake the processor without an interrupt.
  // A line whose pin function is off can never wake it.
  always_comb begin
    next_wake = power_down & (|(irq_flag_reg & wake_enable_reg & pin_func_sel)); // see R2
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      wake_request <= 1'b0;
    end else begin
      wake_request <= next_wake; // see R10
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Status, mask and summary interrupt

  always_comb begin
    status_events[3:0]                         = set_vec & ~irq_flag_reg;
    status_events[ext_irq_pkg::STATUS_WAKE_BIT] = next_wake & ~wake_request;
    status_clear = 5'h00;
    next_mask    = mask_reg;
    if (bus_write && addr_hit(paddr, ext_irq_pkg::STATUS_ADDR)) begin
      status_clear = pwdata[4:0];
    end
    if (bus_write && addr_hit(paddr, ext_irq_pkg::MASK_ADDR)) begin
      next_mask = pwdata[4:0];
    end
    // A new event in the clearing cycle wins, so no event is lost.
    next_status = status_events | (status_reg & ~status_clear);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      status_reg <= ext_irq_pkg::STATUS_RESET;
    end else begin
      status_reg <= next_status;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      mask_reg <= ext_irq_pkg::MASK_RESET;
    end else begin
      mask_reg <= next_mask;
    end
  end

  // Built from the next values, so the output tracks status and mask with no extra delay.
  always_ff @(posedge clock) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_status & next_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb_check @(posedge clock);
  endclocking

  default disable iff (rst);

  // First access cycle of a transfer.
  sequence s_access_start;
    psel && penable && !pready;
  endsequence

  // An answer that stands for exactly one cycle.
  sequence s_answer_pulse;
    pready ##1 !pready;
  endsequence

  a_bus_answer_once: assert property (s_access_start |=> s_answer_pulse) // see R3
    else $error("bus answer is not a single cycle after the access");

  // Some line asks for its flag to be set.
  sequence s_set_seen;
    set_vec != 4'h0;
  endsequence

  a_flag_sets: assert property ( // see R7
    s_set_seen |=> ((irq_flag_reg & $past(set_vec)) == $past(set_vec))
  ) else $error("line flag did not follow its set request");

  a_flag_clears: assert property ( // see R8
    (clear_eff != 4'h0) |=> ((irq_flag_reg & $past(clear_eff)) == 4'h0)
  ) else $error("line flag survived a clear");

  a_flag_no_stray: assert property ( // see R7
    1'b1 |=> ((irq_flag_reg & ~$past(irq_flag_reg) & ~$past(set_vec)) == 4'h0)
  ) else $error("line flag rose without a set request");

  a_func_gates: assert property ( // see R1
    (set_vec & ~pin_func_sel) == 4'h0
  ) else $error("line set request while its pin function is off");

  a_wake_follows: assert property ( // see R10
    (power_down && ((irq_flag_reg & wake_enable_reg & pin_func_sel) != 4'h0)) |=> wake_request
  ) else $error("enabled line pending in power down without a wake request");

  a_irq_level: assert property ( // see R2
    irq == (|(status_reg & mask_reg))
  ) else $error("summary interrupt disagrees with status and mask");

endmodule

`default_nettype wire

// File: verification/ext_pin_model.sv
// Model of the four external interrupt sources.
`timescale 1ns/100ps
`default_nettype none
module ext_pin_model (
  // Clock and command
  input  wire logic       clock,
  input  wire logic [3:0] level,
  // Pins
  output var  logic [3:0] pins
);
  always_ff @(posedge clock) begin
    pins <= level;
  end
endmodule
`default_nettype wire

// File: verification/test_ext_irq_inputs.sv
// Register-level test of the external interrupt inputs.
`timescale 1ns/100ps
`default_nettype none
module test_ext_irq_inputs;
  localparam logic [31:0] FA = ext_irq_pkg::FLAG_ADDR;
  localparam logic [31:0] SA = ext_irq_pkg::STATUS_ADDR;
  logic clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, wake, pd = 1;
  logic pready, pslverr, err, irq;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
  logic [3:0] lv = 4'hf, pins, fl;
  int n_fail = 0, comparisons = 0, cyc = 0;
  always #10 clock = ~clock;
  ext_pin_model PM (.clock(clock), .level(lv), .pins(pins));
  ext_irq_inputs DUT (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_irq_line_a(pins[0]), .ext_irq_line_b(pins[1]),
    .ext_irq_line_c(pins[2]), .ext_irq_line_d(pins[3]), .pin_func_sel(4'hf), .power_down(pd),
    .irq_flag_out(fl), .wake_request(wake), .irq(irq));
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clock);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test;
    if (n_fail == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      stop_test();
    end
  end
  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    bus(0, ext_irq_pkg::SENSE_ADDR, 0);
    check("sense", rd[3:0], ext_irq_pkg::SENSE_RESET);
    bus(1, ext_irq_pkg::WAKE_EN_ADDR, 32'h0000_0001);
    lv <= 4'he;
    bus(1, FA, 32'h0000_0001);
    bus(0, FA, 0);
    check("held", rd[3:0], 4'h1);
    check("wake", wake, 1'b1);
    lv <= 4'hf;
    bus(1, FA, 32'h0000_0001);
    bus(0, FA, 0);
    check("clear", rd[3:0], 4'h0);
    bus(1, ext_irq_pkg::SENSE_ADDR, 32'h0000_0002);
    bus(1, ext_irq_pkg::POLARITY_ADDR, 32'h0000_0002);
    lv <= 4'hd;
    bus(0, FA, 0);
    check("fall", rd[3:0], 4'h0);
    lv <= 4'hf;
    bus(0, FA, 0);
    check("rise", rd[3:0], 4'h2);
    check("out", fl, 4'h2);
    bus(1, FA, 32'h0000_0002);
    bus(0, FA, 0);
    check("edge clr", rd[3:0], 4'h0);
    bus(0, SA, 0);
    check("status", rd[4:0], 5'h13);
    bus(1, ext_irq_pkg::MASK_ADDR, 32'h0000_0002);
    bus(0, ext_irq_pkg::MASK_ADDR, 0);
    check("mask", rd[4:0], 5'h02);
    check("irq on", irq, 1'b1);
    bus(1, SA, 32'h0000_001f);
    bus(0, SA, 0);
    check("status clr", rd[4:0], 5'h00);
    check("irq off", irq, 1'b0);
    bus(0, FA + 32'h0000_0020, 0);
    check("bad addr", err, 1'b1);
    bus(0, FA, 0);
    check("good addr", err, 1'b0);
    stop_test();
  end
endmodule
`default_nettype wire
